// file: emi_pkg.sv
// Purpose: Constants and types for the external data memory interface.
// Assumes: One system clock, synchronous active-high reset.
// Notes: Special function register addresses are byte addresses.
//
// Summary of operation
// - Short form address is page select high byte with chosen pointer low.
// - Long form address is the full sixteen bit data pointer.
// - Data pointer is reachable as separate high and low byte registers.
// - Eight kilobytes of on-chip RAM sit in external space, default target.
// - Pins are owned only while an off-chip external move runs.
// - Drivers of pins acting as inputs are off during the move.
// - Open-drain or push-pull choice is never changed by this block.
// - Large variant has both modes, mid only multiplexed, small none.
// - Page select is eight bits, read/write, resets to zero, picks pages.
package emi_pkg;

  localparam logic [7:0] EMI_SFR_PAGE_SEL = 8'hAA;
  localparam logic [7:0] EMI_SFR_DATA_POINTER_LOW = 8'h82;
  localparam logic [7:0] EMI_SFR_DATA_POINTER_HIGH = 8'h83;
  localparam logic [7:0] EMI_PAGE_SEL_RST = 8'h00;
  localparam logic [7:0] EMI_DATA_POINTER_RST = 8'h00;
  localparam logic [7:0] EMI_IDLE_BYTE = 8'h00;
  localparam int EMI_ONCHIP_BYTES = 8192;
  localparam int EMI_ADDR_SPACE = 65536;

  typedef enum logic [1:0] {
    EMI_MODE_ONCHIP,
    EMI_MODE_SPLIT_NOBANK,
    EMI_MODE_SPLIT_BANK,
    EMI_MODE_OFFCHIP
  } emi_mem_mode_t;

  typedef enum logic [1:0] {
    EMI_VAR_FULL,
    EMI_VAR_MUX_ONLY,
    EMI_VAR_NO_EXT
  } emi_variant_t;

  typedef struct packed {
    logic valid;
    logic long_form;
    logic use_ptr_one;
    logic write;
    logic [7:0] wdata;
  } emi_req_t;

  typedef struct packed {
    logic own;
    logic [7:0] addr_hi;
    logic [7:0] addr_lo;
    logic addr_oe;
    logic [7:0] data;
    logic data_oe;
    logic rd_n;
    logic wr_n;
    logic ale;
    logic ctrl_oe;
  } emi_pins_t;

endpackage : emi_pkg

// file: emi_ext_mem_if.sv
// Purpose: Address generation, on-chip RAM and pin control for external moves.
// Assumes: Requests are taken only while busy is low.
// Notes: Memory mode and multiplexing come from a configuration register
// outside this block and arrive as plain inputs.
`timescale 1ns/1ps

module emi_ext_mem_if #(
  parameter int RAM_BYTES = emi_pkg::EMI_ONCHIP_BYTES,
  parameter emi_pkg::emi_variant_t VARIANT = emi_pkg::EMI_VAR_FULL
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  input wire emi_pkg::emi_req_t req_i,
  input wire logic [7:0] ind_ptr_zero_i,
  input wire logic [7:0] ind_ptr_one_i,
  input wire emi_pkg::emi_mem_mode_t mem_mode_i,
  input wire logic mux_mode_i,
  output logic busy_o,
  output logic done_o,
  output logic [7:0] rdata_o,
  input wire logic [7:0] pin_data_i,
  output emi_pkg::emi_pins_t pins_o
);
  import emi_pkg::*;

  localparam int RAM_AW = $clog2(RAM_BYTES);

  if (RAM_BYTES < 2 || RAM_BYTES > EMI_ADDR_SPACE ||
      (RAM_BYTES & (RAM_BYTES - 1)) != 0) begin : g_bad_ram_bytes
    $error("RAM_BYTES must be a power of two up to 65536.");
  end

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RAM,
    ST_ALE,
    ST_ALE_HOLD,
    ST_STROBE,
    ST_FINISH
  } emi_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Special function registers.

  logic [7:0] page_select_bits_q, page_select_bits_d;
  logic [7:0] data_pointer_high_q, data_pointer_high_d;
  logic [7:0] data_pointer_low_q, data_pointer_low_d;
  logic [7:0] sfr_rdata_q, sfr_rdata_d;

  always_comb begin
    page_select_bits_d = page_select_bits_q;
    data_pointer_high_d = data_pointer_high_q;
    data_pointer_low_d = data_pointer_low_q;
    sfr_rdata_d = sfr_rdata_q;
    if (sfr_wr_i) begin
      case (sfr_addr_i)
        EMI_SFR_PAGE_SEL: page_select_bits_d = sfr_wdata_i;
        EMI_SFR_DATA_POINTER_HIGH: data_pointer_high_d = sfr_wdata_i;
        EMI_SFR_DATA_POINTER_LOW: data_pointer_low_d = sfr_wdata_i;
        default: ;
      endcase
    end
    if (sfr_rd_i) begin
      case (sfr_addr_i)
        EMI_SFR_PAGE_SEL: sfr_rdata_d = page_select_bits_q;
        EMI_SFR_DATA_POINTER_HIGH: sfr_rdata_d = data_pointer_high_q;
        EMI_SFR_DATA_POINTER_LOW: sfr_rdata_d = data_pointer_low_q;
        default: sfr_rdata_d = EMI_IDLE_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      page_select_bits_q <= EMI_PAGE_SEL_RST;
      data_pointer_high_q <= EMI_DATA_POINTER_RST;
      data_pointer_low_q <= EMI_DATA_POINTER_RST;
      sfr_rdata_q <= EMI_IDLE_BYTE;
    end else begin
      page_select_bits_q <= page_select_bits_d;
      data_pointer_high_q <= data_pointer_high_d;
      data_pointer_low_q <= data_pointer_low_d;
      sfr_rdata_q <= sfr_rdata_d;
    end
  end

  assign sfr_rdata_o = sfr_rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Address generation and target selection.

  logic [15:0] eff_addr;
  logic [7:0] ind_low;
  logic split_mode;
  logic go_offchip;
  logic use_mux;

  always_comb begin
    ind_low = req_i.use_ptr_one ? ind_ptr_one_i : ind_ptr_zero_i;
    if (req_i.long_form) begin
      eff_addr = {data_pointer_high_q, data_pointer_low_q};
    end else begin
      eff_addr = {page_select_bits_q, ind_low};
    end
    split_mode = (mem_mode_i == EMI_MODE_SPLIT_NOBANK) ||
                 (mem_mode_i == EMI_MODE_SPLIT_BANK);
    go_offchip = (VARIANT != EMI_VAR_NO_EXT) &&
                 ((mem_mode_i == EMI_MODE_OFFCHIP) ||
                  (split_mode && ({16'h0000, eff_addr} >= RAM_BYTES)));
    use_mux = mux_mode_i || (VARIANT == EMI_VAR_MUX_ONLY);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer.

  emi_state_t state_q, state_d;
  logic [15:0] addr_q, addr_d;
  logic write_q, write_d;
  logic [7:0] wdata_q, wdata_d;
  logic mux_q, mux_d;
  logic busy_q, busy_d;
  logic done_q, done_d;
  logic [7:0] rdata_q, rdata_d;
  emi_pins_t pins_q, pins_d;
  logic [7:0] ram_q [RAM_BYTES];
  logic [RAM_AW-1:0] ram_idx;

  assign ram_idx = addr_q[RAM_AW-1:0];

  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    write_d = write_q;
    wdata_d = wdata_q;
    mux_d = mux_q;
    done_d = 1'b0;
    rdata_d = rdata_q;
    case (state_q)
      ST_IDLE: begin
        if (req_i.valid) begin
          addr_d = eff_addr;
          write_d = req_i.write;
          wdata_d = req_i.wdata;
          mux_d = use_mux;
          if (!go_offchip) begin
            state_d = ST_RAM;
          end else if (use_mux) begin
            state_d = ST_ALE;
          end else begin
            state_d = ST_STROBE;
          end
        end
      end
      ST_RAM: begin
        if (!write_q) begin
          rdata_d = ram_q[ram_idx];
        end
        done_d = 1'b1;
        state_d = ST_IDLE;
      end
      ST_ALE: state_d = ST_ALE_HOLD;
      ST_ALE_HOLD: state_d = ST_STROBE;
      ST_STROBE: state_d = ST_FINISH;
      ST_FINISH: begin
        if (!write_q) begin
          rdata_d = pin_data_i;
        end
        done_d = 1'b1;
        state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
    busy_d = (state_d != ST_IDLE);
  end

  // Pin values follow the next state so every pin output is a flip-flop.
  always_comb begin
    pins_d = '{own: 1'b0, addr_hi: EMI_IDLE_BYTE, addr_lo: EMI_IDLE_BYTE,
               addr_oe: 1'b0, data: EMI_IDLE_BYTE, data_oe: 1'b0,
               rd_n: 1'b1, wr_n: 1'b1, ale: 1'b0, ctrl_oe: 1'b0};
    case (state_d)
      ST_ALE, ST_ALE_HOLD: begin
        pins_d.own = 1'b1;
        pins_d.ctrl_oe = 1'b1;
        pins_d.addr_hi = addr_d[15:8];
        pins_d.addr_oe = 1'b1;
        pins_d.data = addr_d[7:0];
        pins_d.data_oe = 1'b1;
        pins_d.ale = (state_d == ST_ALE);
      end
      ST_STROBE, ST_FINISH: begin
        pins_d.own = 1'b1;
        pins_d.ctrl_oe = 1'b1;
        pins_d.addr_hi = addr_d[15:8];
        pins_d.addr_lo = mux_d ? EMI_IDLE_BYTE : addr_d[7:0];
        pins_d.addr_oe = 1'b1;
        pins_d.data = write_d ? wdata_d : EMI_IDLE_BYTE;
        pins_d.data_oe = write_d;
        pins_d.rd_n = !((state_d == ST_STROBE) && !write_d);
        pins_d.wr_n = !((state_d == ST_STROBE) && write_d);
      end
      default: ;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_q <= ST_IDLE;
      addr_q <= 16'h0000;
      write_q <= 1'b0;
      wdata_q <= EMI_IDLE_BYTE;
      mux_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      rdata_q <= EMI_IDLE_BYTE;
      pins_q <= '{own: 1'b0, addr_hi: EMI_IDLE_BYTE, addr_lo: EMI_IDLE_BYTE,
                  addr_oe: 1'b0, data: EMI_IDLE_BYTE, data_oe: 1'b0,
                  rd_n: 1'b1, wr_n: 1'b1, ale: 1'b0, ctrl_oe: 1'b0};
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
      write_q <= write_d;
      wdata_q <= wdata_d;
      mux_q <= mux_d;
      busy_q <= busy_d;
      done_q <= done_d;
      rdata_q <= rdata_d;
      pins_q <= pins_d;
    end
  end

  // On-chip RAM storage, no reset on the array itself.
  always_ff @(posedge clk_i) begin
    if (state_q == ST_RAM && write_q) begin
      ram_q[ram_idx] <= wdata_q;
    end
  end

  assign busy_o = busy_q;
  assign done_o = done_q;
  assign rdata_o = rdata_q;
  assign pins_o = pins_q;

endmodule : emi_ext_mem_if

// file: emi_ext_mem_if_props.sv
// Purpose: Timing and pin ownership checks.
// Assumes: Full variant, one clock.
// Notes: Bound to the top module.
`timescale 1ns/1ps
module emi_props (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire emi_pkg::emi_req_t req_i,
  input wire emi_pkg::emi_mem_mode_t mem_mode_i,
  input wire logic mux_mode_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire emi_pkg::emi_pins_t pins_o
);
  import emi_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  logic go;
  logic off;
  assign go = req_i.valid && !busy_o;
  assign off = go && mem_mode_i == EMI_MODE_OFFCHIP;
  property p_ch;
    go && mem_mode_i == EMI_MODE_ONCHIP |=> !pins_o.own ##1 done_o;
  endproperty
  a_ch: assert property (p_ch) else $error("on-chip timing");
  property p_mx; off && mux_mode_i |-> ##5 done_o; endproperty
  a_mx: assert property (p_mx) else $error("mux timing");
  property p_nm; off && !mux_mode_i |-> ##3 done_o; endproperty
  a_nm: assert property (p_nm) else $error("non-mux timing");
  property p_ale;
    pins_o.ale |=> !pins_o.ale ##1 (!pins_o.rd_n || !pins_o.wr_n);
  endproperty
  a_ale: assert property (p_ale) else $error("latch order");
  property p_noale; pins_o.own && !mux_mode_i |-> !pins_o.ale; endproperty
  a_noale: assert property (p_noale) else $error("latch used");
  property p_rd; !pins_o.rd_n |-> !pins_o.data_oe && pins_o.wr_n; endproperty
  a_rd: assert property (p_rd) else $error("read drive");
  property p_own;
    pins_o.addr_oe || pins_o.data_oe || pins_o.ctrl_oe |-> pins_o.own;
  endproperty
  a_own: assert property (p_own) else $error("drive unowned");
  property p_rel; done_o |-> !pins_o.own && !pins_o.ctrl_oe; endproperty
  a_rel: assert property (p_rel) else $error("pins kept");
  c_mx: cover property (off && mux_mode_i);
  c_wr: cover property (!pins_o.wr_n);
  c_dn: cover property (done_o);
endmodule : emi_props

bind emi_ext_mem_if emi_props u_props (.clk_i(clk_i), .srst_i(srst_i),
  .req_i(req_i), .mem_mode_i(mem_mode_i), .mux_mode_i(mux_mode_i),
  .busy_o(busy_o), .done_o(done_o), .pins_o(pins_o));

// file: emi_sram_model.sv
// Purpose: Behavioural off-chip memory on the pins.
// Assumes: Strobes sampled on the system clock.
// Notes: Released data lines show a changing pattern.
`timescale 1ns/1ps
module emi_sram_model (
  input wire logic clk_i,
  input wire emi_pkg::emi_pins_t pins_i,
  input wire logic mux_i,
  output logic [7:0] data_o
);
  import emi_pkg::*;
  logic [7:0] mem [0:65535];
  logic [7:0] lat_q = 8'h00;
  logic [7:0] junk_q = 8'hA5;
  logic rd_q = 1'b0;
  logic [15:0] a;
  logic rd_pin, wr_pin, ale_pin;
  logic [7:0] bus;
  assign rd_pin = pins_i.ctrl_oe ? pins_i.rd_n : 1'b1;
  assign wr_pin = pins_i.ctrl_oe ? pins_i.wr_n : 1'b1;
  assign ale_pin = pins_i.ctrl_oe && mux_i && pins_i.ale;
  assign bus = pins_i.data_oe ? pins_i.data : 8'hFF;
  assign a = {pins_i.addr_hi, mux_i ? lat_q : pins_i.addr_lo};
  assign data_o = (!rd_pin || rd_q) ? mem[a] : junk_q;
  always @(posedge clk_i) begin
    if (ale_pin) lat_q <= bus;
    if (!wr_pin) mem[a] <= bus;
    rd_q <= !rd_pin;
    junk_q <= ~junk_q;
  end
endmodule : emi_sram_model

// file: emi_ext_mem_if_bench.sv
// Purpose: Random accesses in all modes, register checks.
// Assumes: On-chip RAM shrunk to 256 bytes.
// Notes: Expected reads come from a shadow copy.
`timescale 1ns/1ps
module emi_ext_mem_if_bench;
  import emi_pkg::*;
  logic clk_i = 0, srst_i = 1, wr_s = 0, rd_s = 0, mux = 0, busy, done;
  logic [7:0] sa = 0, sd = 0, srd, ip0 = 0, ip1 = 0, rdata, pdata, pg;
  logic [15:0] dp;
  logic [31:0] r;
  logic [8:0] n;
  emi_req_t req = '0;
  emi_mem_mode_t mode = EMI_MODE_ONCHIP;
  emi_pins_t pins;
  int num_errors = 0, cmp_count = 0, seed = 32'hDEDED819;
  logic [8:0] notes[$];
  logic [7:0] sh[int];
  always #25 clk_i = ~clk_i;
  emi_ext_mem_if #(.RAM_BYTES(256)) dut (.clk_i(clk_i), .srst_i(srst_i),
    .sfr_addr_i(sa), .sfr_wr_i(wr_s), .sfr_rd_i(rd_s), .sfr_wdata_i(sd),
    .sfr_rdata_o(srd), .req_i(req), .ind_ptr_zero_i(ip0),
    .ind_ptr_one_i(ip1), .mem_mode_i(mode), .mux_mode_i(mux),
    .busy_o(busy), .done_o(done), .rdata_o(rdata), .pin_data_i(pdata),
    .pins_o(pins));
  emi_sram_model far (.clk_i(clk_i), .pins_i(pins), .mux_i(mux),
    .data_o(pdata));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize;
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    sa <= a;
    sd <= d;
    wr_s <= w;
    rd_s <= !w;
    @(posedge clk_i);
    wr_s <= 0;
    rd_s <= 0;
    @(negedge clk_i);
    if (!w) chk(srd, d);
  endtask : sfr
  task automatic acc(input logic lf, p1, wr, input logic [7:0] wd);
    logic [15:0] a;
    logic off, hit;
    int k, i;
    a = lf ? dp : {pg, p1 ? ip1 : ip0};
    off = mode == EMI_MODE_OFFCHIP || (mode != EMI_MODE_ONCHIP && a >= 256);
    k = off ? int'(a) : 65536 + a[7:0];
    hit = sh.exists(k) && !wr;
    notes.push_back({hit, hit ? sh[k] : 8'h00});
    @(posedge clk_i);
    req <= '{1'b1, lf, p1, wr, wd};
    if (wr) sh[k] = wd;
    @(posedge clk_i);
    req.valid <= 1'b0;
    @(negedge clk_i);
    chk({7'h00, pins.own}, {7'h00, off});
    chk({7'h00, busy}, 8'h01);
    if (off) begin
      chk(pins.addr_hi, a[15:8]);
      chk(mux ? pins.data : pins.addr_lo, a[7:0]);
    end
    i = 0;
    while (done !== 1'b1 && i < 20) begin
      @(posedge clk_i);
      i++;
    end
    if (i == 20) num_errors++;
    chk({7'h00, busy}, 8'h00);
  endtask : acc
  always @(posedge clk_i) begin
    if (done === 1'b1 && notes.size() > 0) begin
      n = notes.pop_front();
      if (n[8]) chk(rdata, n[7:0]);
    end
  end
  initial begin
    #1000000;
    num_errors++;
    summarize();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    sfr(0, EMI_SFR_PAGE_SEL, 8'h00);
    sfr(0, EMI_SFR_DATA_POINTER_HIGH, 8'h00);
    sfr(0, 8'h90, 8'h00);
    sfr(1, EMI_SFR_PAGE_SEL, 8'hFF);
    sfr(0, EMI_SFR_PAGE_SEL, 8'hFF);
    sfr(1, EMI_SFR_DATA_POINTER_LOW, 8'h5C);
    sfr(0, EMI_SFR_DATA_POINTER_LOW, 8'h5C);
    $display("registers done");
    for (int t = 0; t < 80; t++) begin
      r = $random(seed);
      pg = {7'h00, r[0]};
      dp = {7'h00, r[1], 6'h00, r[3:2]};
      @(posedge clk_i);
      ip0 <= {6'h00, r[5:4]};
      ip1 <= {6'h00, r[7:6]};
      mode <= emi_mem_mode_t'(r[9:8]);
      mux <= r[10];
      sfr(1, EMI_SFR_PAGE_SEL, pg);
      sfr(1, EMI_SFR_DATA_POINTER_HIGH, dp[15:8]);
      sfr(1, EMI_SFR_DATA_POINTER_LOW, dp[7:0]);
      acc(r[11], r[12], r[13], r[23:16]);
    end
    $display("accesses done");
    sfr(1, EMI_SFR_PAGE_SEL, 8'hFF);
    @(posedge clk_i);
    srst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    sfr(0, EMI_SFR_PAGE_SEL, EMI_PAGE_SEL_RST);
    sfr(0, EMI_SFR_DATA_POINTER_LOW, EMI_DATA_POINTER_RST);
    $display("reset done");
    summarize();
  end
endmodule : emi_ext_mem_if_bench
